// file: uhtxe_pkg.sv
// Constants and types for the host transmit endpoint control block
// What this block does
// - Direction bit 13 set means transmit; matters only with a shared FIFO.
// - DMA requests are raised only while bit 12 is set.
// - Forced toggle bit 11 flips toggle and drops packet without ACK.
// - Bit 9 enables a toggle write and clears itself once stored.
// - Bit 8 reads the toggle; writes count only with bit 9 high.
// - Bulk NAKs past the limit halt the endpoint and set bit 7.
// - Writing one to bit 6 resets the data toggle; write-only.
// - STALL sets bit 5, flushes the FIFO and clears packet ready.
// - Bit 4 with packet ready sends SETUP and clears the toggle.
// - Flush bit 3 drops next packet, clears packet ready; needs it set.
// - Three unanswered bulk or interrupt attempts set bit 2 and interrupt.
// - Bit 1 is set while the FIFO holds at least one packet.
// - Bit 0 set by software; cleared after sending, with an interrupt.
// - Max payload bits 10-0, up to 1024 bytes, upper bits read zero.
package uhtxe_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_CSR = 8'h00;
    localparam logic [7:0] ADDR_MAXP = 8'h04;
    localparam logic [7:0] ADDR_NAKLIM = 8'h08;
    localparam logic [7:0] ADDR_EPCFG = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h14;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h18;
    // Control/status bit positions
    localparam int B_DIR = 13;
    localparam int B_DMA_EN = 12;
    localparam int B_FORCE = 11;
    localparam int B_DMA_MODE = 10;
    localparam int B_TWE = 9;
    localparam int B_TOG = 8;
    localparam int B_NAKTO = 7;
    localparam int B_CLRTOG = 6;
    localparam int B_STALL = 5;
    localparam int B_SETUP = 4;
    localparam int B_FLUSH = 3;
    localparam int B_ERR = 2;
    localparam int B_FNE = 1;
    localparam int B_PKTRDY = 0;
    // Interrupt status bit positions
    localparam int I_TXDONE = 0;
    localparam int I_ERR = 1;
    localparam int I_STALL = 2;
    localparam int I_NAKTO = 3;
    localparam int IRQ_W = 4;
    // Field widths, limits and reset values
    localparam int MAXP_W = 11;
    localparam logic [10:0] MAXP_LIMIT = 11'h400;
    localparam logic [10:0] MAXP_RST = 11'h000;
    localparam logic [7:0] NAKLIM_RST = 8'h00;
    localparam logic [1:0] RETRY_LIMIT = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Endpoint transfer type
    typedef enum logic [1:0] {EP_CTRL, EP_ISO, EP_BULK, EP_INTR} uhtxe_ep_e;
    // Handshake results from the packet engine, one-cycle pulses
    typedef struct packed {
        logic ack;
        logic nak;
        logic stall;
        logic no_hs;
    } uhtxe_evt_s;
    // Transmit request toward the packet engine
    typedef struct packed {
        logic send;
        logic setup;
        logic toggle;
        logic halted;
    } uhtxe_req_s;
endpackage

// file: uhtxe_ctrl.sv
// Host transmit endpoint control, status and AXI4-Lite register slave
//
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module uhtxe_ctrl #(
    parameter int FIFO_PKTS = 2,
    parameter bit SHARED_FIFO = 1'b1
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [7:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [7:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    input wire uhtxe_pkg::uhtxe_evt_s i_evt,
    output uhtxe_pkg::uhtxe_req_s o_req,
    output logic o_dma_req,
    output logic [10:0] o_max_payload,
    output logic o_irq
);
    import uhtxe_pkg::*;

    localparam int CNT_W = $clog2(FIFO_PKTS + 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(FIFO_PKTS);

    logic [7:0] awaddr_ff;
    logic aw_ok_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic w_ok_ff;
    logic wr_go;
    logic [31:0] wm;
    logic [31:0] wd;
    logic map_ok;
    logic [31:0] rd_val;
    logic rd_ok;
    // Control and status state
    logic dir_ff;
    logic dma_en_ff;
    logic force_ff;
    logic dma_mode_ff;
    logic twe_ff;
    logic tog_ff;
    logic nakto_ff;
    logic stall_ff;
    logic setup_ff;
    logic err_ff;
    logic pr_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic [10:0] maxp_ff;
    logic [7:0] naklim_ff;
    uhtxe_ep_e eptype_ff;
    logic [7:0] nakcnt_ff;
    logic [1:0] retry_ff;
    logic [IRQ_W-1:0] ist_ff;
    logic [IRQ_W-1:0] ien_ff;
    // Decoded events
    logic csr_wr;
    logic live;
    logic ev_ack;
    logic ev_nak;
    logic ev_stall;
    logic ev_nohs;
    logic attempt_end;
    logic pkt_done;
    logic flush_go;
    logic sw_pr_set;
    logic bulk_int;
    logic nakto_set;
    logic err_set;
    logic [IRQ_W-1:0] ist_set;
    logic [IRQ_W-1:0] nxt_ist;
    logic [10:0] nxt_maxp;

    // Byte-lane mask and merged write data
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wm[i*8 +: 8] = {8{wstrb_ff[i]}};
        end
        wd = wdata_ff & wm;
    end

    assign wr_go = aw_ok_ff & w_ok_ff & ~o_bvalid;
    assign csr_wr = wr_go & (awaddr_ff == ADDR_CSR);

    // Write address and data are taken independently, one write at a time
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            awaddr_ff <= 8'h00;
            aw_ok_ff <= 1'b0;
            o_awready <= 1'b0;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            w_ok_ff <= 1'b0;
            o_wready <= 1'b0;
        end else if (i_ce) begin
            o_awready <= ~aw_ok_ff & ~(i_awvalid & o_awready) & ~o_bvalid;
            o_wready <= ~w_ok_ff & ~(i_wvalid & o_wready) & ~o_bvalid;
            if (i_awvalid & o_awready) begin
                awaddr_ff <= i_awaddr;
                aw_ok_ff <= 1'b1;
            end else if (wr_go) begin
                aw_ok_ff <= 1'b0;
            end
            if (i_wvalid & o_wready) begin
                wdata_ff <= i_wdata;
                wstrb_ff <= i_wstrb;
                w_ok_ff <= 1'b1;
            end else if (wr_go) begin
                w_ok_ff <= 1'b0;
            end
        end
    end

    // Address decode for writes
    always_comb begin
        case (awaddr_ff)
            ADDR_CSR, ADDR_MAXP, ADDR_NAKLIM, ADDR_EPCFG,
            ADDR_IRQ_EN, ADDR_IRQ_CLR: map_ok = 1'b1;
            default: map_ok = 1'b0;
        endcase
    end

    // Write response, held until the master takes it
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_bvalid <= 1'b0;
            o_bresp <= RESP_OKAY;
        end else if (i_ce) begin
            if (wr_go) begin
                o_bvalid <= 1'b1;
                o_bresp <= map_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    // Read multiplexer; reserved and write-only bits read as zero
    always_comb begin
        rd_ok = 1'b1;
        rd_val = 32'h0000_0000;
        case (i_araddr)
            ADDR_CSR: begin
                rd_val[B_DIR] = dir_ff;
                rd_val[B_DMA_EN] = dma_en_ff;
                rd_val[B_FORCE] = force_ff;
                rd_val[B_DMA_MODE] = dma_mode_ff;
                rd_val[B_TWE] = twe_ff;
                rd_val[B_TOG] = tog_ff;
                rd_val[B_NAKTO] = nakto_ff;
                rd_val[B_STALL] = stall_ff;
                rd_val[B_SETUP] = setup_ff;
                rd_val[B_ERR] = err_ff;
                rd_val[B_FNE] = (cnt_ff != '0);
                rd_val[B_PKTRDY] = pr_ff;
            end
            ADDR_MAXP: rd_val[MAXP_W-1:0] = maxp_ff;
            ADDR_NAKLIM: rd_val[7:0] = naklim_ff;
            ADDR_EPCFG: rd_val[1:0] = eptype_ff;
            ADDR_IRQ_STAT: rd_val[IRQ_W-1:0] = ist_ff;
            ADDR_IRQ_EN: rd_val[IRQ_W-1:0] = ien_ff;
            ADDR_IRQ_CLR: rd_val = 32'h0000_0000;
            default: rd_ok = 1'b0;
        endcase
    end

    // Read channel: address taken when no data is pending
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= RESP_OKAY;
        end else if (i_ce) begin
            o_arready <= ~o_rvalid & ~(i_arvalid & o_arready);
            if (i_arvalid & o_arready) begin
                o_rvalid <= 1'b1;
                o_rdata <= rd_val;
                o_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end

    // Handshake events count only while a send request is out
    assign live = o_req.send;
    assign ev_ack = live & i_evt.ack;
    assign ev_nak = live & i_evt.nak;
    assign ev_stall = live & i_evt.stall;
    assign ev_nohs = live & i_evt.no_hs;
    assign attempt_end = ev_ack | ev_nak | ev_nohs;
    assign pkt_done = ev_ack | (force_ff & attempt_end);
    assign flush_go = csr_wr & wm[B_FLUSH] & wd[B_FLUSH] & pr_ff;
    assign sw_pr_set = csr_wr & wd[B_PKTRDY] & ~pr_ff & (cnt_ff != CNT_FULL);
    assign bulk_int = (eptype_ff == EP_BULK) | (eptype_ff == EP_INTR);
    assign nakto_set = ev_nak & (eptype_ff == EP_BULK) & (naklim_ff != 8'h00)
                       & (nakcnt_ff >= naklim_ff);
    assign err_set = ev_nohs & bulk_int & (retry_ff == RETRY_LIMIT - 2'h1);

    // Software-owned configuration bits of the control register
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            dir_ff <= 1'b0;
            dma_en_ff <= 1'b0;
            force_ff <= 1'b0;
            dma_mode_ff <= 1'b0;
            setup_ff <= 1'b0;
        end else if (i_ce && csr_wr) begin
            if (wm[B_DIR]) dir_ff <= wd[B_DIR];
            if (wm[B_DMA_EN]) dma_en_ff <= wd[B_DMA_EN];
            if (wm[B_FORCE]) force_ff <= wd[B_FORCE];
            if (wm[B_DMA_MODE]) dma_mode_ff <= wd[B_DMA_MODE];
            if (wm[B_SETUP]) setup_ff <= wd[B_SETUP];
        end
    end

    // Toggle write enable is a one-cycle mark of a stored toggle
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            twe_ff <= 1'b0;
        end else if (i_ce) begin
            twe_ff <= csr_wr & wd[B_TWE];
        end
    end

    // Data toggle: clears first, then explicit writes, then flips
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            tog_ff <= 1'b0;
        end else if (i_ce) begin
            if (csr_wr & (wd[B_CLRTOG] | wd[B_SETUP])) begin
                tog_ff <= 1'b0;
            end else if (csr_wr & wd[B_TWE] & wm[B_TOG]) begin
                tog_ff <= wd[B_TOG];
            end else if (pkt_done) begin
                tog_ff <= ~tog_ff;
            end
        end
    end

    // Packet ready: set by software, cleared by send, stall or flush
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            pr_ff <= 1'b0;
        end else if (i_ce) begin
            if (pkt_done | ev_stall | flush_go) begin
                pr_ff <= 1'b0;
            end else if (sw_pr_set) begin
                pr_ff <= 1'b1;
            end
        end
    end

    // Packets held in the FIFO; one leaves per send or flush
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_ff <= '0;
        end else if (i_ce) begin
            if (ev_stall) begin
                cnt_ff <= '0;
            end else if ((pkt_done | flush_go) & ~sw_pr_set) begin
                cnt_ff <= cnt_ff - CNT_W'(1);
            end else if (sw_pr_set & ~(pkt_done | flush_go)) begin
                cnt_ff <= cnt_ff + CNT_W'(1);
            end
        end
    end

    // Sticky flags: hardware set wins over a software clear
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            nakto_ff <= 1'b0;
            stall_ff <= 1'b0;
            err_ff <= 1'b0;
        end else if (i_ce) begin
            if (nakto_set) nakto_ff <= 1'b1;
            else if (csr_wr & wm[B_NAKTO]) nakto_ff <= wd[B_NAKTO];
            if (ev_stall) stall_ff <= 1'b1;
            else if (csr_wr & wm[B_STALL]) stall_ff <= wd[B_STALL];
            if (err_set) err_ff <= 1'b1;
            else if (csr_wr & wm[B_ERR]) err_ff <= wd[B_ERR];
        end
    end

    // NAK and no-handshake counters, restarted whenever a packet leaves
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            nakcnt_ff <= 8'h00;
            retry_ff <= 2'h0;
        end else if (i_ce) begin
            if (pkt_done | ev_stall | flush_go | nakto_set) begin
                nakcnt_ff <= 8'h00;
            end else if (ev_nak & (nakcnt_ff != 8'hff)) begin
                nakcnt_ff <= nakcnt_ff + 8'h01;
            end
            if (pkt_done | ev_stall | flush_go | err_set) begin
                retry_ff <= 2'h0;
            end else if (ev_nohs) begin
                retry_ff <= retry_ff + 2'h1;
            end
        end
    end

    // Payload limit clamped to the largest legal size
    always_comb begin
        nxt_maxp = maxp_ff;
        if (wm[0]) nxt_maxp[7:0] = wd[7:0];
        if (wm[8]) nxt_maxp[10:8] = wd[10:8];
        if (nxt_maxp > MAXP_LIMIT) nxt_maxp = MAXP_LIMIT;
    end

    // Other configuration registers
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            maxp_ff <= MAXP_RST;
            naklim_ff <= NAKLIM_RST;
            eptype_ff <= EP_CTRL;
        end else if (i_ce && wr_go) begin
            if (awaddr_ff == ADDR_MAXP) maxp_ff <= nxt_maxp;
            if (awaddr_ff == ADDR_NAKLIM && wm[0]) naklim_ff <= wd[7:0];
            if (awaddr_ff == ADDR_EPCFG && wm[0]) begin
                eptype_ff <= uhtxe_ep_e'(wd[1:0]);
            end
        end
    end

    // Interrupt sources
    always_comb begin
        ist_set = '0;
        ist_set[I_TXDONE] = pkt_done & pr_ff;
        ist_set[I_ERR] = err_set;
        ist_set[I_STALL] = ev_stall;
        ist_set[I_NAKTO] = nakto_set;
        nxt_ist = ist_ff;
        if (wr_go && awaddr_ff == ADDR_IRQ_CLR) begin
            nxt_ist = ist_ff & ~wd[IRQ_W-1:0];
        end
        nxt_ist = nxt_ist | ist_set;
    end

    // Interrupt status, enable and output level
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            ist_ff <= '0;
            ien_ff <= '0;
            o_irq <= 1'b0;
        end else if (i_ce) begin
            ist_ff <= nxt_ist;
            if (wr_go && awaddr_ff == ADDR_IRQ_EN && wm[0]) begin
                ien_ff <= wd[IRQ_W-1:0];
            end
            o_irq <= |(nxt_ist & ien_ff);
        end
    end

    // Outputs toward the packet engine and the DMA controller
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_req <= '0;
            o_dma_req <= 1'b0;
            o_max_payload <= MAXP_RST;
        end else if (i_ce) begin
            o_req.halted <= nakto_ff | stall_ff | err_ff;
            o_req.send <= pr_ff & ~(pkt_done | ev_stall | flush_go)
                          & ~(nakto_ff | nakto_set | stall_ff | ev_stall)
                          & ~(err_ff | err_set)
                          & (dir_ff | ~SHARED_FIFO);
            o_req.setup <= setup_ff;
            o_req.toggle <= tog_ff;
            o_dma_req <= dma_en_ff & (dir_ff | ~SHARED_FIFO)
                         & (cnt_ff != CNT_FULL) & ~pr_ff;
            o_max_payload <= maxp_ff;
        end
    end
endmodule

// file: uhtxe_ctrl_monitor.sv
// Port-level checker for the host transmit endpoint control block
`timescale 1ns/10ps
module uhtxe_ctrl_monitor
    import uhtxe_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_araddr,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic [31:0] o_rdata,
    input wire logic o_rvalid,
    input wire uhtxe_pkg::uhtxe_evt_s i_evt,
    input wire uhtxe_pkg::uhtxe_req_s o_req,
    input wire logic o_dma_req,
    input wire logic [10:0] o_max_payload
);
    logic [7:0] ar_ff;
    logic live;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    // Remember the address of the read being answered
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            ar_ff <= 8'h00;
        end else if (i_arvalid && o_arready) begin
            ar_ff <= i_araddr;
        end
    end
    // A handshake only counts against an open, unhalted request
    assign live = o_req.send && !o_req.halted;
    a_dma_vs_send: assert property (
        o_dma_req |-> !o_req.send)
        else $error("dma request while a packet is pending");
    a_ack_release: assert property (
        i_evt.ack && live |-> ##[1:2] !o_req.send)
        else $error("request still open after ack");
    a_stall_halts: assert property (
        i_evt.stall && live |-> ##[1:2] (o_req.halted && !o_req.send))
        else $error("stall did not halt and drop the request");
    a_setup_toggle: assert property (
        $rose(o_req.send) && o_req.setup |-> !o_req.toggle)
        else $error("setup packet sent with toggle one");
    a_halt_blocks: assert property (
        o_req.halted [*2] |-> !o_req.send)
        else $error("request open while halted");
    a_csr_readback: assert property (
        o_rvalid && ar_ff == ADDR_CSR |-> o_rdata[31:14] == 18'h0
        && !o_rdata[6] && !o_rdata[3] && (!o_rdata[0] || o_rdata[1]))
        else $error("control word read back wrongly");
    a_maxp_upper: assert property (
        o_rvalid && ar_ff == ADDR_MAXP |-> o_rdata[31:11] == 21'h0)
        else $error("max payload upper bits not zero");
    a_maxp_limit: assert property (
        o_max_payload <= MAXP_LIMIT)
        else $error("max payload above limit");
    c_ack: cover property (i_evt.ack && live);
    c_nak: cover property (i_evt.nak && live);
    c_stall: cover property (i_evt.stall && live);
    c_nohs: cover property (i_evt.no_hs && live);
endmodule

// file: uhtxe_peer.sv
// Behavioural peripheral answering each transmit request with a handshake
`timescale 1ns/10ps
module uhtxe_peer
    import uhtxe_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire uhtxe_pkg::uhtxe_req_s i_req,
    input wire logic [1:0] i_kind,
    input wire logic [3:0] i_gap,
    output uhtxe_pkg::uhtxe_evt_s o_evt
);
    logic [3:0] wait_ff;
    // Wait the turnaround, then pulse one handshake of the chosen kind
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            wait_ff <= 4'h0;
            o_evt <= uhtxe_evt_s'(4'h0);
        end else if (!i_req.send || wait_ff == i_gap) begin
            wait_ff <= 4'h0;
            o_evt <= i_req.send ? uhtxe_evt_s'(4'h8 >> i_kind)
                : uhtxe_evt_s'(4'h0);
        end else begin
            wait_ff <= wait_ff + 4'h1;
            o_evt <= uhtxe_evt_s'(4'h0);
        end
    end
endmodule

// file: usb_host_tx_endpoint_ctrl_test.sv
// Self-checking bench for the host transmit endpoint control block
`timescale 1ns/10ps
module usb_host_tx_endpoint_ctrl_test;
    import uhtxe_pkg::*;
    localparam logic [31:0] DIR = 32'h2000;
    localparam logic [31:0] RDY = 32'h1;
    localparam logic [31:0] TOG = 32'h100;
    localparam logic [31:0] TWE = 32'h200;
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_ce = 1'b1;
    logic [7:0] i_awaddr = 8'h00;
    logic [7:0] i_araddr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic [3:0] i_wstrb = 4'hf;
    logic i_awvalid = 1'b0;
    logic i_wvalid = 1'b0;
    logic i_bready = 1'b0;
    logic i_arvalid = 1'b0;
    logic i_rready = 1'b0;
    logic [1:0] kind = 2'h0;
    logic [3:0] gap = 4'h1;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic o_dma_req, o_irq;
    logic [1:0] o_bresp, o_rresp;
    logic [31:0] o_rdata;
    logic [1:0] last_bresp;
    logic [10:0] o_max_payload;
    uhtxe_evt_s i_evt;
    uhtxe_req_s o_req;
    int miscompares = 0;
    int n_compared = 0;
    int cyc = 0;
    uhtxe_ctrl uhtxe_ctrl_inst (.i_sys_clk, .i_rst, .i_ce, .i_awaddr,
        .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready,
        .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready,
        .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_evt, .o_req, .o_dma_req,
        .o_max_payload, .o_irq);
    uhtxe_peer uhtxe_peer_inst (.i_sys_clk, .i_rst, .i_req(o_req),
        .i_kind(kind), .i_gap(gap), .o_evt(i_evt));
    // Clock and hang guard
    always #10 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            results();
        end
    end
    task automatic results();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Bus write: address and data offered together, held until taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        do begin
            @(posedge i_sys_clk);
            if (o_awready) i_awvalid <= 1'b0;
            if (o_wready) i_wvalid <= 1'b0;
        end while (!o_bvalid);
        last_bresp = o_bresp;
        i_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
            output logic [1:0] r);
        @(posedge i_sys_clk);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        do begin
            @(posedge i_sys_clk);
            if (o_arready) i_arvalid <= 1'b0;
        end while (!o_rvalid);
        d = o_rdata;
        r = o_rresp;
        i_rready <= 1'b0;
    endtask
    // Read a register, or keep reading until a field settles, and compare
    task automatic poll(input logic [7:0] a, input logic [31:0] m,
            input logic [31:0] e, input int tries);
        logic [31:0] d;
        logic [1:0] r;
        int n;
        n = 0;
        do begin
            rd(a, d, r);
            n++;
        end while ((d & m) !== e && n < tries);
        chk(d & m, e);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] m,
            input logic [31:0] e);
        poll(a, m, e, 1);
    endtask
    task automatic t_reset();
        logic [31:0] d;
        logic [1:0] r;
        rc(ADDR_CSR, 32'hffff_ffff, 32'h0);
        rc(ADDR_MAXP, 32'hffff_ffff, 32'h0);
        rd(8'h40, d, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        wr(8'h40, 32'h1);
        chk({30'h0, last_bresp}, {30'h0, RESP_SLVERR});
        $display("test reset done");
    endtask
    task automatic t_maxp();
        wr(ADDR_MAXP, 32'hffff_ffff);
        chk({30'h0, last_bresp}, {30'h0, RESP_OKAY});
        rc(ADDR_MAXP, 32'hffff_ffff, 32'h400);
        wr(ADDR_MAXP, 32'h0000_01ff);
        rc(ADDR_MAXP, 32'hffff_ffff, 32'h1ff);
        chk({21'h0, o_max_payload}, 32'h1ff);
        $display("test max payload done");
    endtask
    task automatic t_toggle();
        wr(ADDR_CSR, DIR | TWE | TOG);
        rc(ADDR_CSR, TWE | TOG, TOG);
        wr(ADDR_CSR, DIR);
        rc(ADDR_CSR, TOG, TOG);
        wr(ADDR_CSR, DIR | 32'h40);
        rc(ADDR_CSR, TOG, 32'h0);
        $display("test toggle done");
    endtask
    task automatic t_send();
        kind <= 2'h0;
        gap <= 4'hf;
        wr(ADDR_IRQ_EN, 32'h1);
        wr(ADDR_CSR, DIR | TWE | TOG);
        wr(ADDR_CSR, DIR | 32'h10 | RDY);
        rc(ADDR_CSR, TOG | 32'h3, 32'h3);
        chk({31'h0, o_req.setup}, 32'h1);
        chk({31'h0, o_req.toggle}, 32'h0);
        poll(ADDR_CSR, RDY, 32'h0, 50);
        rc(ADDR_CSR, TOG | 32'h2, TOG);
        chk({31'h0, o_req.toggle}, 32'h1);
        chk({31'h0, o_irq}, 32'h1);
        wr(ADDR_IRQ_CLR, 32'h1);
        rc(ADDR_IRQ_STAT, 32'hf, 32'h0);
        chk({31'h0, o_irq}, 32'h0);
        kind <= 2'h1;
        wr(ADDR_CSR, DIR | 32'h800 | RDY);
        poll(ADDR_CSR, RDY, 32'h0, 50);
        rc(ADDR_CSR, TOG, 32'h0);
        wr(ADDR_IRQ_CLR, 32'hf);
        $display("test send done");
    endtask
    task automatic t_stall();
        kind <= 2'h2;
        gap <= 4'h1;
        wr(ADDR_CSR, DIR | RDY);
        poll(ADDR_CSR, 32'h23, 32'h20, 50);
        rc(ADDR_IRQ_STAT, 32'h4, 32'h4);
        wr(ADDR_CSR, DIR);
        rc(ADDR_CSR, 32'h20, 32'h0);
        $display("test stall done");
    endtask
    task automatic t_err();
        kind <= 2'h3;
        wr(ADDR_EPCFG, 32'h2);
        wr(ADDR_IRQ_EN, 32'h2);
        wr(ADDR_CSR, DIR | RDY);
        poll(ADDR_CSR, 32'h4, 32'h4, 50);
        rc(ADDR_IRQ_STAT, 32'h2, 32'h2);
        chk({31'h0, o_irq}, 32'h1);
        wr(ADDR_CSR, DIR | 32'h4 | 32'h8);
        wr(ADDR_CSR, DIR | 32'h4 | 32'h8);
        rc(ADDR_CSR, 32'h7, 32'h4);
        wr(ADDR_CSR, DIR);
        rc(ADDR_CSR, 32'h4, 32'h0);
        wr(ADDR_IRQ_CLR, 32'hf);
        $display("test retry error done");
    endtask
    task automatic t_nak();
        kind <= 2'h1;
        gap <= 4'hf;
        wr(ADDR_NAKLIM, 32'h1);
        wr(ADDR_CSR, DIR | RDY);
        // First NAK lands near cycle 20, the second near cycle 36
        repeat (20) @(posedge i_sys_clk);
        rc(ADDR_CSR, 32'h81, 32'h1);
        poll(ADDR_CSR, 32'h81, 32'h81, 50);
        chk({31'h0, o_req.halted}, 32'h1);
        wr(ADDR_CSR, DIR | 32'h88);
        wr(ADDR_CSR, DIR);
        rc(ADDR_CSR, 32'h83, 32'h0);
        $display("test nak timeout done");
    endtask
    task automatic t_dma();
        wr(ADDR_CSR, 32'h1000);
        rc(ADDR_CSR, 32'h1000, 32'h1000);
        chk({31'h0, o_dma_req}, 32'h0);
        wr(ADDR_CSR, DIR | 32'h1000);
        rc(ADDR_CSR, 32'h1000, 32'h1000);
        chk({31'h0, o_dma_req}, 32'h1);
        wr(ADDR_CSR, DIR);
        rc(ADDR_CSR, 32'h1000, 32'h0);
        chk({31'h0, o_dma_req}, 32'h0);
        $display("test dma done");
    endtask
    // Main sequence
    initial begin
        repeat (8) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        t_reset();
        t_maxp();
        t_toggle();
        t_send();
        t_stall();
        t_err();
        t_nak();
        t_dma();
        results();
    end
endmodule
bind uhtxe_ctrl uhtxe_ctrl_monitor uhtxe_ctrl_monitor_inst (.i_sys_clk,
    .i_rst, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rvalid, .i_evt,
    .o_req, .o_dma_req, .o_max_payload);
